// [bench/sebl_eeprom.sv]
`timescale 1ns/100ps
module sebl_eeprom (
  // Serial link
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_mosi,
  output logic o_miso,
  // Device kind: two address bytes when high
  input wire logic i_two_byte
);
  logic [7:0] mem [0:511];
  logic [7:0] op;
  logic [23:0] a;
  int n, h, k;

  initial begin
    o_miso = 1'b0;
    op = 8'h00;
    a = 24'h000000;
    n = 0;
  end

  // Opcode and address capture on the rising clock
  always @(posedge i_sclk) begin
    h = i_two_byte ? 24 : 32;
    if (!i_cs_n) begin
      if (n < 8) op = {op[6:0], i_mosi};
      else if (n < h) a = {a[22:0], i_mosi};
      n = n + 1;
    end
  end

  // Data leaves on the falling clock; an undriven line keeps toggling
  always @(negedge i_sclk or posedge i_cs_n) begin
    h = i_two_byte ? 24 : 32;
    if (i_cs_n) begin
      n = 0;
      a = 24'h000000;
      o_miso = ~o_miso;
    end else if (op == 8'h03 && n >= h) begin
      k = n - h;
      o_miso = mem[(int'(a) + k / 8) % 512][7 - k % 8];
    end else o_miso = ~o_miso;
  end
endmodule : sebl_eeprom

// [bench/sebl_loader_bench.sv]
`timescale 1ns/100ps
module sebl_loader_bench import sebl_pkg::*;;
  logic i_clock, i_rst, i_avs_read, i_avs_write, i_sys_ready;
  logic [4:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, rd;
  logic [3:0] i_avs_byteenable;
  logic o_avs_waitrequest, o_sys_valid, o_exec_start, o_chip_reset_request;
  logic o_chip_select0_n, o_sclk, o_serial_data_out, i_serial_data_in;
  logic dev_two;
  logic [35:0] o_exec_addr;
  sebl_sys_req_s o_sys_req;
  sebl_sys_req_s ev [3];
  sebl_sys_req_s sysq [$];
  int n_fail, check_count;

  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  sebl_loader i_dut (.i_clock, .i_rst, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
    .o_avs_waitrequest, .o_sys_valid, .o_sys_req, .i_sys_ready,
    .o_exec_start, .o_exec_addr, .o_chip_reset_request, .o_chip_select0_n,
    .o_sclk, .o_serial_data_out, .i_serial_data_in);
  sebl_eeprom i_mem (.i_cs_n(o_chip_select0_n), .i_sclk(o_sclk),
    .i_mosi(o_serial_data_out), .o_miso(i_serial_data_in),
    .i_two_byte(dev_two));

  // Sink stalls every other cycle so held requests get exercised
  always @(posedge i_clock) begin
    i_sys_ready <= i_rst ? 1'b0 : ~i_sys_ready;
    if (o_sys_valid === 1'b1 && i_sys_ready) sysq.push_back(o_sys_req);
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [67:0] got, input logic [67:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task stop_test;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // Avalon cycle: hold until waitrequest is seen low at an edge
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    logic ok;
    ok = 1'b0;
    @(posedge i_clock);
    i_avs_read <= ~w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    for (int j = 0; j < 20 && !ok; j++) begin
      @(posedge i_clock);
      ok = (o_avs_waitrequest === 1'b0);
    end
    rd = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    if (!ok) begin
      n_fail++;
      stop_test();
    end
  endtask : bus

  task put(input int a, input logic [31:0] v);
    for (int b = 0; b < 4; b++) i_mem.mem[a + b] = v[31 - 8 * b -: 8];
  endtask : put

  // Optional restart, then wait for jump or reset request
  task run(input logic kick);
    int c;
    if (kick) begin
      sysq.delete();
      bus(1'b1, SEBL_OFS_CTRL, 32'h0000_0001);
    end
    for (c = 0; c < 50 && o_exec_start === 1'b1; c++) @(posedge i_clock);
    for (c = 0; c < 80000; c++) begin
      @(posedge i_clock);
      if (o_exec_start === 1'b1 || o_chip_reset_request === 1'b1) break;
    end
    if (c == 80000) begin
      n_fail++;
      stop_test();
    end
  endtask : run

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    bus(1'b0, SEBL_OFS_MODE, 32'h0);
    chk(rd, SEBL_MODE_RESET);
    bus(1'b0, 5'h10, 32'h0);
    chk(rd, 32'h0);
    // Faster link keeps the run short; rate change must still land
    bus(1'b1, SEBL_OFS_MODE, 32'h0307_0000);
    bus(1'b0, SEBL_OFS_MODE, 32'h0);
    chk(rd, 32'h0307_0000);
    $display("register test done");
  endtask : t_regs

  task t_boot(input logic two);
    dev_two = two;
    run(two);
    chk(o_exec_start, 1'b1);
    chk(o_exec_addr, 36'h0_0000_2000);
    chk(sysq.size(), 3);
    for (int j = 0; j < 3; j++) chk(sysq[j], ev[j]);
    bus(1'b0, SEBL_OFS_MODE, 32'h0);
    chk(rd, 32'h0007_0000);
    bus(1'b0, SEBL_OFS_STATUS, 32'h0);
    chk(rd[3], two);
    $display("boot test done, two-byte %0d", two);
  endtask : t_boot

  task t_fail;
    put('h40, 32'h0);
    run(1'b1);
    chk(o_chip_reset_request, 1'b1);
    chk(o_chip_select0_n, 1'b1);
    chk(o_exec_start, 1'b0);
    bus(1'b0, SEBL_OFS_STATUS, 32'h0);
    chk(rd[2], 1'b1);
    $display("bad signature test done");
  endtask : t_fail

  // ----------------------------------------------------------------
  // Image, reset and sequence
  // ----------------------------------------------------------------
  initial begin
    i_rst = 1'b1;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_address = 5'h00;
    i_avs_writedata = 32'h0;
    i_avs_byteenable = 4'hF;
    dev_two = 1'b0;
    n_fail = 0;
    check_count = 0;
    for (int j = 0; j < 512; j++) i_mem.mem[j] = 8'h00;
    put('h40, SEBL_SIGNATURE);
    put('h48, 32'h8);
    put('h50, 32'h100);
    put('h58, 32'h1000);
    put('h60, 32'h2000);
    put('h68, 32'h4);
    put('h80, 32'hFFFF_FF00);
    put('h84, 32'h0123_4567);
    put('h88, 32'h4000_0001);
    put('h8C, 32'h2);
    put('h90, 32'h2000_0001);
    put('h94, 32'hE0FF_FFFF);
    put('h98, 32'h8000_0001);
    put('h100, 32'h1111_2222);
    put('h104, 32'h3333_4444);
    ev[0] = {36'h0_FFFF_FF00, 32'h0123_4567};
    ev[1] = {36'h0_0000_1000, 32'h1111_2222};
    ev[2] = {36'h0_0000_1004, 32'h3333_4444};
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    t_regs();
    t_boot(1'b0);
    t_boot(1'b1);
    t_fail();
    stop_test();
  end
endmodule : sebl_loader_bench

// [bench/sebl_loader_chk.sv]
`timescale 1ns/100ps
module sebl_loader_chk import sebl_pkg::*; (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Bus and system side
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic o_sys_valid,
  input wire sebl_sys_req_s o_sys_req,
  input wire logic i_sys_ready,
  input wire logic o_exec_start,
  input wire logic [35:0] o_exec_addr,
  input wire logic o_chip_reset_request,
  // Serial link
  input wire logic o_chip_select0_n,
  input wire logic o_sclk,
  input wire logic o_serial_data_out
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // ----------------------------------------------------------------
  // Serial link
  // ----------------------------------------------------------------
  a_idle_clock_low: assert property (
    o_chip_select0_n |-> !o_sclk) else $error("sclk high while idle");
  a_data_on_fall: assert property (
    !o_chip_select0_n && $past(!o_chip_select0_n) &&
    $changed(o_serial_data_out) |-> !o_sclk)
    else $error("data changed with sclk high");
  a_fresh_gap: assert property (
    $rose(o_chip_select0_n) |-> o_chip_select0_n [*8])
    else $error("select gap too short");
  a_fail_quiet: assert property (
    o_chip_reset_request |-> o_chip_select0_n && !o_sclk)
    else $error("link active after reset request");

  // ----------------------------------------------------------------
  // System writes, jump and bus
  // ----------------------------------------------------------------
  a_sys_addr_ok: assert property (
    o_sys_valid |-> o_sys_req.addr[35:32] == 4'h0 &&
    o_sys_req.addr[1:0] == 2'h0) else $error("bad write address");
  a_sys_hold: assert property (
    o_sys_valid && !i_sys_ready |=> o_sys_valid && $stable(o_sys_req))
    else $error("write request dropped or changed");
  a_sys_drop: assert property (
    o_sys_valid && i_sys_ready |=> !o_sys_valid)
    else $error("write request held after accept");
  a_exec_top: assert property (
    o_exec_start |-> o_exec_addr[35:32] == 4'h0 && $stable(o_exec_addr))
    else $error("bad jump address");
  a_bus_one_wait: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("more than one wait cycle");
endmodule : sebl_loader_chk

bind sebl_loader sebl_loader_chk i_chk (.i_clock, .i_rst, .i_avs_read,
  .i_avs_write, .o_avs_waitrequest, .o_sys_valid, .o_sys_req, .i_sys_ready,
  .o_exec_start, .o_exec_addr, .o_chip_reset_request, .o_chip_select0_n,
  .o_sclk, .o_serial_data_out);

// [rtl/sebl_loader.sv]
// Functional notes
// - Address word lsb selects data write (0) or control instruction (1).
// - End flag stops configuration and starts the code copy.
// - Pause flag waits data word count times eight clocks.
// - Rate change copies only prescale and extra divide into mode register.
// - Rate change is applied after all config words, with CS parked.
// - Loader is master; chip select 0 alone enables the memory.
// - Data leaves on falling clock edge, is captured on rising edge.
// - Serial clock rests low while idle.
// - Eight-bit characters, most significant bit first.
// - Default serial clock is the platform clock divided by 256.
// - Non-sequential reads send opcode 03 and the address bytes.
// - Sequential reads keep clocking without a new command.
// - Signature tried with three address bytes, then with two.
// - First data bit after 24 or 32 serial clocks.
// - Image addresses map to 36 bits with top four bits zero.
// - Signature missing in both modes: stop link, request chip reset.
// - Data-mode address word writes data word to aligned address.
// - Pair count at most 1024; that many pairs processed unless an end flag stops earlier.
// - Copy code bytes from source to target, then start execution.
`timescale 1ns/100ps
module sebl_loader import sebl_pkg::*; (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // System write master
  output logic o_sys_valid,
  output sebl_sys_req_s o_sys_req,
  input wire logic i_sys_ready,
  // Boot outcome
  output logic o_exec_start,
  output logic [35:0] o_exec_addr,
  output logic o_chip_reset_request,
  // Serial memory link
  output logic o_chip_select0_n,
  output logic o_sclk,
  output logic o_serial_data_out,
  input wire logic i_serial_data_in
);

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_SIG, ST_HDR, ST_CADDR, ST_CDATA, ST_CWR, ST_PAUSE, ST_NEXT,
    ST_CFG_END, ST_FREQ, ST_COPY_RD, ST_COPY_WR, ST_DONE, ST_FAIL
  } sebl_main_e;

  typedef enum logic [2:0] {
    F_IDLE, F_GAP, F_SEND, F_WAIT
  } sebl_fetch_e;

  typedef struct packed {
    sebl_main_e main;
    sebl_fetch_e fetch;
    logic in_data;
    logic [2:0] idx;
    logic [7:0] gap;
    logic got;
    logic [31:0] word;
    logic [31:0] faddr;
    logic [31:0] next_addr;
    logic seq_ok;
    logic cs_active;
    logic addr16;
    logic spi_go;
    logic [7:0] tx;
    logic [2:0] hdr;
    logic [31:0] ptr;
    logic [31:0] len;
    logic [31:0] src;
    logic [31:0] tgt;
    logic [31:0] exec;
    logic [31:0] npairs;
    logic [31:0] pair_idx;
    logic [31:0] caddr;
    logic freq_pending;
    logic [31:0] freq_data;
    logic [34:0] pause_left;
    logic [29:0] left;
    logic sys_valid;
    sebl_sys_req_s sys_req;
    logic exec_start;
    logic reset_req;
    logic [31:0] mode;
    logic ack;
    logic [31:0] rdata;
  } sebl_state_s;

  sebl_state_s s_reg;
  sebl_state_s s_next;

  logic spi_busy;
  logic spi_done;
  logic [7:0] spi_rx;
  logic [9:0] half_period;
  logic [3:0] prescale_field;

  // ----------------------------------------------------------------
  // Serial clock divider from the mode register
  // ----------------------------------------------------------------
  // Divide = 4*(prescale+1), times 16 with extra divide; reset gives 256
  assign prescale_field = s_reg.mode[SEBL_MODE_PRESCALE_LSB +: 4];
  assign half_period = (10'({1'b0, prescale_field} + 5'h01) << 1) *
    (s_reg.mode[SEBL_MODE_XDIV_BIT] ? SEBL_XDIV_FACTOR : 10'h001);

  // Byte shifter on the serial pins
  sebl_spi_byte u_spi (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_start(s_reg.spi_go),
    .i_tx_byte(s_reg.tx),
    .i_half_period(half_period),
    .o_busy(spi_busy),
    .o_done(spi_done),
    .o_rx_byte(spi_rx),
    .o_sclk(o_sclk),
    .o_serial_data_out(o_serial_data_out),
    .i_serial_data_in(i_serial_data_in)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic want;
    logic [31:0] waddr;
    logic restart;
    logic [31:0] be_mask;
    want = 1'b0;
    waddr = s_reg.ptr;
    restart = 1'b0;
    be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
      {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    s_next = s_reg;
    s_next.spi_go = 1'b0;

    // Bus slave: one wait cycle, then answer at the next edge
    s_next.ack = (i_avs_read | i_avs_write) & ~s_reg.ack;
    if (i_avs_read && !s_reg.ack) begin
      if (i_avs_address == SEBL_OFS_STATUS) begin
        s_next.rdata = {28'h0000000, s_reg.addr16, s_reg.reset_req,
          s_reg.exec_start, (s_reg.main != ST_DONE) &&
          (s_reg.main != ST_FAIL)};
      end else if (i_avs_address == SEBL_OFS_MODE) begin
        s_next.rdata = s_reg.mode;
      end else if (i_avs_address == SEBL_OFS_EXEC) begin
        s_next.rdata = s_reg.exec;
      end else begin
        s_next.rdata = 32'h0000_0000;
      end
    end
    if (i_avs_write && s_reg.ack) begin
      if (i_avs_address == SEBL_OFS_CTRL) begin
        restart = i_avs_byteenable[0] &
          i_avs_writedata[SEBL_CTRL_RESTART_BIT];
      end else if (i_avs_address == SEBL_OFS_MODE) begin
        s_next.mode = (s_reg.mode & ~be_mask) | (i_avs_writedata & be_mask);
      end
    end

    // Loader sequence
    case (s_reg.main)
      ST_SIG: begin
        want = !s_reg.got;
        waddr = SEBL_ADR_SIGNATURE;
        if (s_reg.got) begin
          s_next.got = 1'b0;
          if (s_reg.word == SEBL_SIGNATURE) begin
            s_next.main = ST_HDR;
            s_next.hdr = 3'h0;
            s_next.ptr = SEBL_ADR_HEADER;
          end else if (!s_reg.addr16) begin
            s_next.addr16 = 1'b1;
            s_next.cs_active = 1'b0;
            s_next.seq_ok = 1'b0;
          end else begin
            s_next.cs_active = 1'b0;
            s_next.reset_req = 1'b1;
            s_next.main = ST_FAIL;
          end
        end
      end
      ST_HDR: begin
        want = !s_reg.got;
        if (s_reg.got) begin
          s_next.got = 1'b0;
          s_next.ptr = s_reg.ptr + SEBL_HEADER_STEP;
          s_next.hdr = s_reg.hdr + 3'h1;
          case (s_reg.hdr)
            3'h0: s_next.len = s_reg.word;
            3'h1: s_next.src = s_reg.word;
            3'h2: s_next.tgt = s_reg.word;
            3'h3: s_next.exec = s_reg.word;
            default: s_next.npairs = s_reg.word;
          endcase
          if (s_reg.hdr == SEBL_HDR_LAST) begin
            s_next.ptr = SEBL_ADR_PAIRS;
            s_next.pair_idx = 32'h0000_0000;
            if (s_reg.word > SEBL_MAX_PAIRS) begin
              s_next.cs_active = 1'b0;
              s_next.main = ST_FAIL;
            end else if (s_reg.word == 32'h0000_0000) begin
              s_next.main = ST_CFG_END;
            end else begin
              s_next.main = ST_CADDR;
            end
          end
        end
      end
      ST_CADDR: begin
        want = !s_reg.got;
        if (s_reg.got) begin
          s_next.got = 1'b0;
          s_next.caddr = s_reg.word;
          s_next.ptr = s_reg.ptr + SEBL_WORD_STEP;
          if (s_reg.word[SEBL_KIND_BIT] && s_reg.word[SEBL_END_BIT]) begin
            s_next.main = ST_CFG_END;
          end else begin
            s_next.main = ST_CDATA;
          end
        end
      end
      ST_CDATA: begin
        want = !s_reg.got;
        if (s_reg.got) begin
          s_next.got = 1'b0;
          s_next.ptr = s_reg.ptr + SEBL_WORD_STEP;
          s_next.main = ST_NEXT;
          if (!s_reg.caddr[SEBL_KIND_BIT]) begin
            s_next.sys_req.addr = {4'h0, s_reg.caddr[31:2], 2'b00};
            s_next.sys_req.data = s_reg.word;
            s_next.sys_valid = 1'b1;
            s_next.main = ST_CWR;
          end else if (s_reg.caddr[SEBL_PAUSE_BIT]) begin
            s_next.pause_left = 35'(s_reg.word) << SEBL_PAUSE_SHIFT;
            if (s_reg.word != 32'h0000_0000) begin
              s_next.main = ST_PAUSE;
            end
          end else if (s_reg.caddr[SEBL_RATE_BIT]) begin
            s_next.freq_pending = 1'b1;
            s_next.freq_data = s_reg.word;
          end
        end
      end
      ST_CWR: begin
        if (i_sys_ready) begin
          s_next.sys_valid = 1'b0;
          s_next.main = ST_NEXT;
        end
      end
      ST_PAUSE: begin
        // Link stays selected; a sequential read resumes afterwards
        s_next.pause_left = s_reg.pause_left - 35'h000000001;
        if (s_reg.pause_left == 35'h000000001) begin
          s_next.main = ST_NEXT;
        end
      end
      ST_NEXT: begin
        s_next.pair_idx = s_reg.pair_idx + 32'h0000_0001;
        if (s_reg.pair_idx + 32'h0000_0001 == s_reg.npairs) begin
          s_next.main = ST_CFG_END;
        end else begin
          s_next.main = ST_CADDR;
        end
      end
      ST_CFG_END: begin
        s_next.ptr = s_reg.src;
        s_next.left = s_reg.len[31:2];
        if (s_reg.freq_pending) begin
          s_next.main = ST_FREQ;
        end else if (s_reg.len[31:2] == 30'h00000000) begin
          s_next.exec_start = 1'b1;
          s_next.main = ST_DONE;
        end else begin
          s_next.main = ST_COPY_RD;
        end
      end
      ST_FREQ: begin
        // Park the link first so no character sees a half-changed rate
        s_next.cs_active = 1'b0;
        s_next.seq_ok = 1'b0;
        if (!spi_busy && !s_reg.cs_active) begin
          s_next.mode = (s_reg.mode & ~SEBL_MODE_FREQ_MASK) |
            (s_reg.freq_data & SEBL_MODE_FREQ_MASK);
          s_next.freq_pending = 1'b0;
          s_next.main = ST_CFG_END;
        end
      end
      ST_COPY_RD: begin
        want = !s_reg.got;
        if (s_reg.got) begin
          s_next.got = 1'b0;
          s_next.ptr = s_reg.ptr + SEBL_WORD_STEP;
          s_next.sys_req.addr = {4'h0, s_reg.tgt};
          s_next.sys_req.data = s_reg.word;
          s_next.sys_valid = 1'b1;
          s_next.main = ST_COPY_WR;
        end
      end
      ST_COPY_WR: begin
        if (i_sys_ready) begin
          s_next.sys_valid = 1'b0;
          s_next.tgt = s_reg.tgt + SEBL_WORD_STEP;
          s_next.left = s_reg.left - 30'h00000001;
          if (s_reg.left == 30'h00000001) begin
            s_next.cs_active = 1'b0;
            s_next.exec_start = 1'b1;
            s_next.main = ST_DONE;
          end else begin
            s_next.main = ST_COPY_RD;
          end
        end
      end
      default: begin
        // Done or failed: wait for a software restart
        if (restart) begin
          s_next.main = ST_SIG;
          s_next.addr16 = 1'b0;
          s_next.exec_start = 1'b0;
          s_next.reset_req = 1'b0;
          s_next.seq_ok = 1'b0;
          s_next.freq_pending = 1'b0;
        end
      end
    endcase

    // Word fetch from the serial memory
    case (s_reg.fetch)
      F_IDLE: begin
        if (want) begin
          s_next.faddr = waddr;
          s_next.word = 32'h0000_0000;
          s_next.idx = 3'h0;
          if (s_reg.seq_ok && s_reg.cs_active && waddr == s_reg.next_addr) begin
            s_next.in_data = 1'b1;
            s_next.fetch = F_SEND;
          end else begin
            s_next.cs_active = 1'b0;
            s_next.in_data = 1'b0;
            s_next.gap = SEBL_CS_GAP;
            s_next.fetch = F_GAP;
          end
        end
      end
      F_GAP: begin
        s_next.gap = s_reg.gap - 8'h01;
        if (s_reg.gap == 8'h01) begin
          s_next.cs_active = 1'b1;
          s_next.fetch = F_SEND;
        end
      end
      F_SEND: begin
        s_next.spi_go = 1'b1;
        s_next.fetch = F_WAIT;
        if (s_reg.in_data) begin
          s_next.tx = SEBL_OP_DUMMY;
        end else begin
          case (s_reg.idx)
            3'h0: s_next.tx = SEBL_OP_READ;
            3'h1: s_next.tx = s_reg.faddr[23:16];
            3'h2: s_next.tx = s_reg.faddr[15:8];
            default: s_next.tx = s_reg.faddr[7:0];
          endcase
        end
      end
      default: begin
        if (spi_done) begin
          s_next.fetch = F_SEND;
          s_next.idx = s_reg.idx + 3'h1;
          if (!s_reg.in_data) begin
            // Two-byte mode skips the top address byte
            if (s_reg.idx == 3'h0 && s_reg.addr16) begin
              s_next.idx = 3'h2;
            end
            if (s_reg.idx == SEBL_ADDR_BYTES_LAST) begin
              s_next.in_data = 1'b1;
              s_next.idx = 3'h0;
            end
          end else begin
            s_next.word = {s_reg.word[23:0], spi_rx};
            if (s_reg.idx == SEBL_DATA_BYTES_LAST) begin
              s_next.got = 1'b1;
              s_next.seq_ok = 1'b1;
              s_next.next_addr = s_reg.faddr + SEBL_WORD_STEP;
              s_next.fetch = F_IDLE;
            end
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s_reg <= '0;
      s_reg.main <= ST_SIG;
      s_reg.fetch <= F_IDLE;
      s_reg.mode <= SEBL_MODE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~s_reg.ack;
  assign o_avs_readdata = s_reg.rdata;
  assign o_sys_valid = s_reg.sys_valid;
  assign o_sys_req = s_reg.sys_req;
  assign o_exec_start = s_reg.exec_start;
  assign o_exec_addr = {4'h0, s_reg.exec};
  assign o_chip_reset_request = s_reg.reset_req;
  assign o_chip_select0_n = ~s_reg.cs_active;

endmodule : sebl_loader

// [rtl/sebl_pkg.sv]
package sebl_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [4:0] SEBL_OFS_CTRL = 5'h00;
  localparam logic [4:0] SEBL_OFS_STATUS = 5'h04;
  localparam logic [4:0] SEBL_OFS_MODE = 5'h08;
  localparam logic [4:0] SEBL_OFS_EXEC = 5'h0C;
  localparam int SEBL_CTRL_RESTART_BIT = 0;

  // ----------------------------------------------------------------
  // Chip select 0 mode register
  // ----------------------------------------------------------------
  localparam logic [31:0] SEBL_MODE_RESET = 32'h3307_0000;
  localparam logic [31:0] SEBL_MODE_FREQ_MASK = 32'h1F00_0000;
  localparam int SEBL_MODE_XDIV_BIT = 28;
  localparam int SEBL_MODE_PRESCALE_LSB = 24;
  localparam logic [9:0] SEBL_XDIV_FACTOR = 10'h010;

  // ----------------------------------------------------------------
  // Image layout and word encodings
  // ----------------------------------------------------------------
  localparam logic [31:0] SEBL_ADR_SIGNATURE = 32'h0000_0040;
  localparam logic [31:0] SEBL_ADR_HEADER = 32'h0000_0048;
  localparam logic [31:0] SEBL_HEADER_STEP = 32'h0000_0008;
  localparam logic [31:0] SEBL_ADR_PAIRS = 32'h0000_0080;
  localparam logic [31:0] SEBL_WORD_STEP = 32'h0000_0004;
  localparam logic [31:0] SEBL_SIGNATURE = 32'h424F_4F54;
  localparam logic [31:0] SEBL_MAX_PAIRS = 32'h0000_0400;
  localparam logic [2:0] SEBL_HDR_LAST = 3'h4;
  localparam int SEBL_KIND_BIT = 0;
  localparam int SEBL_END_BIT = 31;
  localparam int SEBL_PAUSE_BIT = 30;
  localparam int SEBL_RATE_BIT = 29;
  localparam logic [7:0] SEBL_OP_READ = 8'h03;
  localparam logic [7:0] SEBL_OP_DUMMY = 8'h00;
  localparam logic [2:0] SEBL_ADDR_BYTES_LAST = 3'h3;
  localparam logic [2:0] SEBL_DATA_BYTES_LAST = 3'h3;
  localparam logic [7:0] SEBL_CS_GAP = 8'h08;
  localparam logic [2:0] SEBL_PAUSE_SHIFT = 3'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [35:0] addr;
    logic [31:0] data;
  } sebl_sys_req_s;

  typedef struct packed {
    logic busy;
    logic done;
    logic sclk;
    logic mosi;
    logic [7:0] shift;
    logic [7:0] rx;
    logic [3:0] bits;
    logic [9:0] ticks;
  } sebl_spi_s;

endpackage : sebl_pkg

// [rtl/sebl_spi_byte.sv]
`timescale 1ns/100ps
module sebl_spi_byte import sebl_pkg::*; (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Byte request
  input wire logic i_start,
  input wire logic [7:0] i_tx_byte,
  input wire logic [9:0] i_half_period,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rx_byte,
  // Serial pins
  output logic o_sclk,
  output logic o_serial_data_out,
  input wire logic i_serial_data_in
);

  sebl_spi_s s_reg;
  sebl_spi_s s_next;

  // ----------------------------------------------------------------
  // One eight-bit character, mode 0, msb first
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (!s_reg.busy) begin
      s_next.sclk = 1'b0;
      if (i_start) begin
        s_next.busy = 1'b1;
        s_next.shift = i_tx_byte;
        s_next.mosi = i_tx_byte[7];
        s_next.bits = 4'h0;
        s_next.ticks = i_half_period - 10'h001;
      end
    end else if (s_reg.ticks != 10'h000) begin
      s_next.ticks = s_reg.ticks - 10'h001;
    end else begin
      s_next.ticks = i_half_period - 10'h001;
      if (!s_reg.sclk) begin
        // Rising edge: capture
        s_next.sclk = 1'b1;
        s_next.rx = {s_reg.rx[6:0], i_serial_data_in};
        s_next.bits = s_reg.bits + 4'h1;
      end else begin
        // Falling edge: launch next bit or finish low
        s_next.sclk = 1'b0;
        if (s_reg.bits == 4'h8) begin
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
        end else begin
          s_next.shift = {s_reg.shift[6:0], 1'b0};
          s_next.mosi = s_reg.shift[6];
        end
      end
    end
  end

  // State register
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flops
  assign o_busy = s_reg.busy;
  assign o_done = s_reg.done;
  assign o_rx_byte = s_reg.rx;
  assign o_sclk = s_reg.sclk;
  assign o_serial_data_out = s_reg.mosi;

endmodule : sebl_spi_byte
